// file: lmlf_ctrl.sv
// lmlf_ctrl: control bank for level meter, loopbacks and filter enables
// assumes command strobes synchronous to ref_clk_i, one byte pair each
module lmlf_ctrl #(
  parameter int unsigned FRAME_CYCLES = lmlf_pkg::FRAME_CYCLES
) (
  input  wire logic                                     ref_clk_i,
  input  wire logic                                     rst_i,
  input  wire logic                                     cmd_stb_i,
  input  wire logic [7:0]                               cmd_i,
  input  wire logic [7:0]                               wdata_i,
  input  wire logic [lmlf_pkg::CH_W-1:0]                chan_sel_i,
  input  wire logic [lmlf_pkg::NUM_CH*lmlf_pkg::PCM_W-1:0] pcm_data_i,
  input  wire logic [lmlf_pkg::NUM_CH*lmlf_pkg::IE_W-1:0]  sig_in_i,
  input  wire logic [lmlf_pkg::NUM_CH*lmlf_pkg::SB_PINS-1:0] sb_is_out_i,
  output logic      [7:0]                               rdata_o,
  output logic                                          rvalid_o,
  output logic      [lmlf_pkg::NUM_CH*8-1:0]            coef_en_o,
  output logic      [lmlf_pkg::NUM_CH*lmlf_pkg::LCL_LOOP_W-1:0] lcl_loop_o,
  output logic      [lmlf_pkg::GLB_LOOP_W-1:0]          glb_loop_o,
  output logic                                          synth_power_down_o,
  output logic      [lmlf_pkg::NUM_CH-1:0]              input_change_irq_o
);
  import lmlf_pkg::*;

  initial begin
    if (FRAME_CYCLES < 2) $error("frame period too short");
  end

  // command decode
  logic             is_wr;
  logic [6:0]       code;
  logic             hi_read;

  assign is_wr   = cmd_i[CMD_WR_BIT];
  assign code    = cmd_i[CODE_W-1:0];
  assign hi_read = cmd_stb_i && !is_wr && code == CODE_RES_HI;

  function automatic logic wr_hit(input logic [6:0] c);
    wr_hit = cmd_stb_i && is_wr && code == c;
  endfunction

  // software-visible shadows
  logic [7:0]        coef_sh_ff [NUM_CH];
  logic [7:0]        lcl_sh_ff  [NUM_CH];
  logic [7:0]        count_ff;
  logic [MODE_W-1:0] mode_ff;
  logic [5:0]        glb_sh_ff;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        coef_sh_ff[c] <= RST_COEF;
        lcl_sh_ff[c]  <= RST_ZERO;
      end
    end else if (wr_hit(CODE_COEF)) begin
      coef_sh_ff[chan_sel_i] <= wdata_i;
    end else if (wr_hit(CODE_LOCAL)) begin
      lcl_sh_ff[chan_sel_i] <= wdata_i;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_ff  <= RST_ZERO;
      mode_ff   <= '0;
      glb_sh_ff <= '0;
    end else begin
      if (wr_hit(CODE_COUNT)) begin
        count_ff <= wdata_i;
      end
      if (wr_hit(CODE_MODE)) begin
        mode_ff <= wdata_i[MODE_W-1:0];
      end
      if (wr_hit(CODE_GLOBAL)) begin
        glb_sh_ff <= wdata_i[5:0];
      end
    end
  end

  // power-down acts at once: it is what stops the frame clock itself
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      synth_power_down_o <= 1'b0;
    end else begin
      synth_power_down_o <= glb_sh_ff[GLB_PD_BIT];
    end
  end

  // frame enable
  logic frame_tick;

  lmlf_frame_tick #(
    .CYCLES (FRAME_CYCLES)
  ) u_tick (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .halt_i    (synth_power_down_o),
    .tick_o    (frame_tick)
  );

  // enables applied only on a frame boundary, never mid-sample
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
        coef_en_o[c*8 +: 8]                   <= RST_COEF;
        lcl_loop_o[c*LCL_LOOP_W +: LCL_LOOP_W] <= '0;
      end
      glb_loop_o <= '0;
    end else if (frame_tick) begin
      for (int c = 0; c < NUM_CH; c++) begin
        coef_en_o[c*8 +: 8] <= coef_sh_ff[c];
        lcl_loop_o[c*LCL_LOOP_W +: LCL_LOOP_W] <=
          lcl_sh_ff[c][LCL_LOOP_W-1:0];
      end
      glb_loop_o <= glb_sh_ff[GLB_LOOP_W-1:0];
    end
  end

  // level meter on the selected channel
  logic [PCM_W-1:0] sel_sample;
  logic [PCM_W-1:0] res_val;
  logic             res_done;
  logic             rdy_ff;

  assign sel_sample = pcm_data_i[mode_ff[MODE_CH_LSB +: CH_W]*PCM_W +: PCM_W];

  lmlf_meter u_meter (
    .ref_clk_i (ref_clk_i),
    .rst_i     (rst_i),
    .tick_i    (frame_tick),
    .on_i      (mode_ff[MODE_ON_BIT]),
    .lin_i     (mode_ff[MODE_LIN_BIT]),
    .count_i   (count_ff),
    .sample_i  (sel_sample),
    .result_o  (res_val),
    .done_o    (res_done)
  );

  // a result landing with the high-byte read wins over the clear
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdy_ff <= 1'b0;
    end else if (res_done) begin
      rdy_ff <= 1'b1;
    end else if (hi_read) begin
      rdy_ff <= 1'b0;
    end
  end

  // read path
  logic [7:0] nxt_rdata;

  always_comb begin
    unique case (code)
      CODE_COEF:   nxt_rdata = coef_sh_ff[chan_sel_i];
      CODE_LOCAL:  nxt_rdata = lcl_sh_ff[chan_sel_i];
      CODE_RES_LO: nxt_rdata = {res_val[7:1], rdy_ff};
      CODE_RES_HI: nxt_rdata = res_val[15:8];
      CODE_COUNT:  nxt_rdata = count_ff;
      CODE_MODE:   nxt_rdata = {4'h0, mode_ff};
      CODE_GLOBAL: nxt_rdata = {2'h0, glb_sh_ff};
      default:     nxt_rdata = RST_ZERO;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o  <= RST_ZERO;
      rvalid_o <= 1'b0;
    end else begin
      rvalid_o <= cmd_stb_i && !is_wr;
      if (cmd_stb_i && !is_wr) begin
        rdata_o <= nxt_rdata;
      end
    end
  end

  // input-change interrupts
  logic [NUM_CH*IE_W-1:0] sig_prev_ff;
  logic [NUM_CH-1:0]      nxt_irq;

  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      logic [IE_W-1:0] chg;
      logic [IE_W-1:0] usable;
      chg    = sig_in_i[c*IE_W +: IE_W] ^ sig_prev_ff[c*IE_W +: IE_W];
      // sense inputs always count, sideband pins only as inputs
      usable = {~sb_is_out_i[c*SB_PINS +: SB_PINS], 2'b11};
      nxt_irq[c] = |(chg & usable & lcl_sh_ff[c][LCL_IE_LSB +: IE_W]);
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sig_prev_ff        <= '0;
      input_change_irq_o <= '0;
    end else begin
      sig_prev_ff        <= sig_in_i;
      input_change_irq_o <= nxt_irq;
    end
  end

  property p_rdy_clear;
    @(posedge ref_clk_i) disable iff (rst_i)
      hi_read && !res_done |=> !rdy_ff;
  endproperty
  a_rdy_clear: assert property (p_rdy_clear)
    else $error("ready bit survived high byte read");

  property p_rdy_set;
    @(posedge ref_clk_i) disable iff (rst_i)
      res_done |=> rdy_ff;
  endproperty
  a_rdy_set: assert property (p_rdy_set)
    else $error("ready bit missed a finished result");

  property p_hold_between;
    @(posedge ref_clk_i) disable iff (rst_i)
      !frame_tick |=> $stable(glb_loop_o) && $stable(coef_en_o);
  endproperty
  a_hold_between: assert property (p_hold_between)
    else $error("enables changed off a frame boundary");

  property p_apply;
    @(posedge ref_clk_i) disable iff (rst_i)
      frame_tick |=> glb_loop_o == $past(glb_sh_ff[GLB_LOOP_W-1:0]);
  endproperty
  a_apply: assert property (p_apply)
    else $error("global loopbacks not applied at frame");

  property p_irq_gate;
    @(posedge ref_clk_i) disable iff (rst_i)
      lcl_sh_ff[0][LCL_IE_LSB +: IE_W] == '0 |=> !input_change_irq_o[0];
  endproperty
  a_irq_gate: assert property (p_irq_gate)
    else $error("interrupt raised with enables clear");

  property p_sb_out_quiet;
    @(posedge ref_clk_i) disable iff (rst_i)
      sb_is_out_i[0] &&
      (sig_in_i[IE_W-1:0] ^ sig_prev_ff[IE_W-1:0]) == 5'h04 |=>
        !input_change_irq_o[0];
  endproperty
  a_sb_out_quiet: assert property (p_sb_out_quiet)
    else $error("output sideband pin raised interrupt");

  property p_read_back;
    @(posedge ref_clk_i) disable iff (rst_i)
      wr_hit(CODE_COUNT) ##1 !wr_hit(CODE_COUNT) ##1
        cmd_stb_i && cmd_i == {1'b0, CODE_COUNT} |=>
        rvalid_o && rdata_o == $past(wdata_i, 3);
  endproperty
  a_read_back: assert property (p_read_back)
    else $error("count register read back wrong");

  property p_hi_ro;
    @(posedge ref_clk_i) disable iff (rst_i)
      wr_hit(CODE_RES_HI) && !frame_tick |=> $stable(res_val);
  endproperty
  a_hi_ro: assert property (p_hi_ro)
    else $error("write altered read-only result");

  property p_pd_follow;
    @(posedge ref_clk_i) disable iff (rst_i)
      wr_hit(CODE_GLOBAL) |=> ##1 synth_power_down_o ==
        $past(wdata_i[GLB_PD_BIT], 2);
  endproperty
  a_pd_follow: assert property (p_pd_follow)
    else $error("power-down output not following register");

  // a tick already launched may still land in the first halted cycle
  property p_pd_freeze;
    @(posedge ref_clk_i) disable iff (rst_i)
      synth_power_down_o && $past(synth_power_down_o) |=>
        $stable(glb_loop_o) && $stable(coef_en_o);
  endproperty
  a_pd_freeze: assert property (p_pd_freeze)
    else $error("enables applied while synthesiser powered down");

  property p_lcl_hold;
    @(posedge ref_clk_i) disable iff (rst_i)
      !frame_tick |=> $stable(lcl_loop_o);
  endproperty
  a_lcl_hold: assert property (p_lcl_hold)
    else $error("local loopbacks changed off a frame boundary");

  property p_coef_apply;
    @(posedge ref_clk_i) disable iff (rst_i)
      frame_tick |=> coef_en_o[BYTE_W-1:0] == $past(coef_sh_ff[0]);
  endproperty
  a_coef_apply: assert property (p_coef_apply)
    else $error("coefficient enables not applied at frame");

  property p_lcl_apply;
    @(posedge ref_clk_i) disable iff (rst_i)
      frame_tick |=> lcl_loop_o[LCL_LOOP_W-1:0] ==
        $past(lcl_sh_ff[0][LCL_LOOP_W-1:0]);
  endproperty
  a_lcl_apply: assert property (p_lcl_apply)
    else $error("local loopbacks not applied at frame");

  property p_irq_sense;
    @(posedge ref_clk_i) disable iff (rst_i)
      lcl_sh_ff[0][LCL_IE_LSB] && sig_in_i[0] != sig_prev_ff[0] |=>
        input_change_irq_o[0];
  endproperty
  a_irq_sense: assert property (p_irq_sense)
    else $error("enabled sense input change gave no interrupt");

  property p_lo_ready;
    @(posedge ref_clk_i) disable iff (rst_i)
      cmd_stb_i && !is_wr && code == CODE_RES_LO |=>
        rdata_o[RDY_BIT] == $past(rdy_ff);
  endproperty
  a_lo_ready: assert property (p_lo_ready)
    else $error("low byte read did not carry ready bit");

  property p_rvalid_read;
    @(posedge ref_clk_i) disable iff (rst_i)
      cmd_stb_i && !is_wr |=> rvalid_o;
  endproperty
  a_rvalid_read: assert property (p_rvalid_read)
    else $error("read command not answered");

  property p_rvalid_quiet;
    @(posedge ref_clk_i) disable iff (rst_i)
      !cmd_stb_i || is_wr |=> !rvalid_o;
  endproperty
  a_rvalid_quiet: assert property (p_rvalid_quiet)
    else $error("read valid without a read command");
endmodule

// file: lmlf_frame_tick.sv
// lmlf_frame_tick: one-cycle frame enable every frame period
// assumes halt_i is a registered level from the control bank
module lmlf_frame_tick #(
  parameter int unsigned CYCLES = lmlf_pkg::FRAME_CYCLES
) (
  input  wire logic ref_clk_i,
  input  wire logic rst_i,
  input  wire logic halt_i,
  output logic      tick_o
);
  import lmlf_pkg::*;

  localparam int unsigned CNT_W = $clog2(CYCLES);

  logic [CNT_W-1:0] cnt_ff;

  initial begin
    if (CYCLES < 2) $error("frame tick needs at least two cycles");
  end

  // a halted synthesiser freezes the frame count where it stands
  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_ff <= '0;
      tick_o <= 1'b0;
    end else if (halt_i) begin
      tick_o <= 1'b0;
    end else if (cnt_ff == CNT_W'(CYCLES - 1)) begin
      cnt_ff <= '0;
      tick_o <= 1'b1;
    end else begin
      cnt_ff <= cnt_ff + CNT_W'(1);
      tick_o <= 1'b0;
    end
  end

  property p_halt_no_tick;
    @(posedge ref_clk_i) disable iff (rst_i)
      halt_i |=> !tick_o;
  endproperty
  a_halt_no_tick: assert property (p_halt_no_tick)
    else $error("frame tick while synthesiser powered down");
endmodule

// file: lmlf_host.sv
// lmlf_host: host side of the command port, changes lines on falling edges
// assumes the bank answers a read one clock edge after taking it
module lmlf_host (
  input  wire logic       ref_clk_i,
  input  wire logic       rvalid_i,
  input  wire logic [7:0] rdata_i,
  output logic            cmd_stb_o,
  output logic      [7:0] cmd_o,
  output logic      [7:0] wdata_o,
  output logic      [1:0] chan_sel_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    cmd_stb_o = 1'b0;
    cmd_o = 8'h00;
    wdata_o = 8'h00;
    chan_sel_o = 2'h0;
  end
  task automatic send(input logic w, input logic [6:0] code,
                      input logic [7:0] dv, input logic [1:0] ch);
    @(negedge ref_clk_i);
    cmd_stb_o = 1'b1;
    cmd_o = {w, code};
    wdata_o = dv;
    chan_sel_o = ch;
    @(negedge ref_clk_i);
    cmd_stb_o = 1'b0;
    // released lines flip so stale values are never trusted
    cmd_o = ~cmd_o;
    wdata_o = ~wdata_o;
    chan_sel_o = ~chan_sel_o;
  endtask
  task automatic rd(input logic [6:0] code, input logic [1:0] ch,
                    output logic [7:0] dv);
    send(1'b0, code, 8'h00, ch);
    // read valid stands one cycle only: take it at the release edge
    dv = (rvalid_i === 1'b1) ? rdata_i : 8'hXX;
  endtask
endmodule

// file: lmlf_meter.sv
// lmlf_meter: level meter, peak magnitude of one channel over N frames in linear mode with a nonzero count
// assumes tick_i is the frame enable and sample_i is stable at the tick
module lmlf_meter (
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_i,
  input  wire logic                       tick_i,
  input  wire logic                       on_i,
  input  wire logic                       lin_i,
  input  wire logic [7:0]                 count_i,
  input  wire logic [lmlf_pkg::PCM_W-1:0] sample_i,
  output logic      [lmlf_pkg::PCM_W-1:0] result_o,
  output logic                            done_o
);
  import lmlf_pkg::*;

  logic [7:0]       frames_ff;
  logic [PCM_W-1:0] peak_ff;
  logic [PCM_W-1:0] mag;
  logic [PCM_W-1:0] nxt_peak;

  function automatic logic [PCM_W-1:0] magnitude(input logic [PCM_W-1:0] s);
    magnitude = s[PCM_W-1] ? PCM_W'(-s) : s;
  endfunction

  assign mag      = magnitude(sample_i);
  assign nxt_peak = (mag > peak_ff) ? mag : peak_ff;

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      frames_ff <= '0;
      peak_ff   <= '0;
      result_o  <= '0;
      done_o    <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (!on_i) begin
        // held result, window restarts when switched back on
        frames_ff <= '0;
        peak_ff   <= '0;
      end else if (tick_i) begin
        if (!lin_i) begin
          result_o <= {sample_i[7:0], RST_ZERO};
          done_o   <= 1'b1;
        end else if (count_i == 8'h00) begin
          result_o <= sample_i;
          done_o   <= 1'b1;
        end else if (frames_ff + 8'h01 == count_i) begin
          result_o  <= nxt_peak;
          done_o    <= 1'b1;
          frames_ff <= '0;
          peak_ff   <= '0;
        end else begin
          frames_ff <= frames_ff + 8'h01;
          peak_ff   <= nxt_peak;
        end
      end
    end
  end

  property p_off_hold;
    @(posedge ref_clk_i) disable iff (rst_i)
      !on_i |=> $stable(result_o) && !done_o;
  endproperty
  a_off_hold: assert property (p_off_hold)
    else $error("meter result moved while meter off");

  property p_comp_pass;
    @(posedge ref_clk_i) disable iff (rst_i)
      tick_i && on_i && !lin_i |=>
        done_o && result_o[15:8] == $past(sample_i[7:0]);
  endproperty
  a_comp_pass: assert property (p_comp_pass)
    else $error("compressed sample not passed to high byte");

  property p_direct;
    @(posedge ref_clk_i) disable iff (rst_i)
      tick_i && on_i && lin_i && count_i == 8'h00 |=>
        done_o && result_o == $past(sample_i);
  endproperty
  a_direct: assert property (p_direct)
    else $error("zero count did not pass sample directly");
endmodule

// file: lmlf_pkg.sv
// lmlf_pkg: constants for the level meter, loopback and filter control bank
// assumes one 200 MHz clock and a byte-wide serial control command port
package lmlf_pkg;
  // command byte layout
  localparam int unsigned CMD_WR_BIT  = 7;
  localparam int unsigned CODE_W      = 7;
  localparam int unsigned BYTE_W      = 8;
  // register codes (command byte without the write bit)
  localparam logic [6:0] CODE_COEF    = 7'h00;
  localparam logic [6:0] CODE_LOCAL   = 7'h01;
  localparam logic [6:0] CODE_RES_LO  = 7'h31;
  localparam logic [6:0] CODE_RES_HI  = 7'h32;
  localparam logic [6:0] CODE_COUNT   = 7'h33;
  localparam logic [6:0] CODE_MODE    = 7'h34;
  localparam logic [6:0] CODE_GLOBAL  = 7'h35;
  // reset values
  localparam logic [7:0] RST_COEF     = 8'h08;
  localparam logic [7:0] RST_ZERO     = 8'h00;
  // mode register fields
  localparam int unsigned MODE_ON_BIT  = 3;
  localparam int unsigned MODE_LIN_BIT = 2;
  localparam int unsigned MODE_CH_LSB  = 0;
  localparam int unsigned MODE_W       = 4;
  // global register fields
  localparam int unsigned GLB_PD_BIT   = 5;
  localparam int unsigned GLB_LOOP_W   = 5;
  // local register fields
  localparam int unsigned LCL_IE_LSB   = 3;
  localparam int unsigned LCL_LOOP_W   = 3;
  localparam int unsigned IE_W         = 5;
  // ready flag position in the result low byte
  localparam int unsigned RDY_BIT      = 0;
  // channel and signalling layout
  localparam int unsigned NUM_CH       = 4;
  localparam int unsigned CH_W         = 2;
  localparam int unsigned SB_PINS      = 3;
  localparam int unsigned PCM_W        = 16;
  // timing
  localparam int unsigned FRAME_PERIOD_NS = 125000;
  localparam int unsigned CLK_PERIOD_NS   = 5;
  localparam int unsigned FRAME_CYCLES    = FRAME_PERIOD_NS / CLK_PERIOD_NS;
endpackage

// file: testbench.sv
// testbench: self-checking bench for the lmlf_ctrl control bank
// assumes lmlf_host drives the command port; short frame for speed
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import lmlf_pkg::*;
  localparam int unsigned FC = 8;
  logic        ref_clk;
  logic        rst;
  logic        cmd_stb;
  logic [7:0]  cmd;
  logic [7:0]  wdata;
  logic [1:0]  chan_sel;
  logic [63:0] pcm;
  logic [19:0] sig_in;
  logic [11:0] sb_out;
  logic [7:0]  rdata;
  logic        rvalid;
  logic [31:0] coef_en;
  logic [11:0] lcl_loop;
  logic [4:0]  glb_loop;
  logic        pd;
  logic [3:0]  irq;
  int          n_fail;
  int          comparisons;
  logic [7:0]  m_coef [4];
  logic [7:0]  m_local [4];
  logic [7:0]  m_cnt;
  logic [7:0]  m_mode;
  logic [7:0]  m_glob;
  logic [31:0] r;
  logic [31:0] ec;
  logic [11:0] el;
  int          c;

  lmlf_ctrl #(.FRAME_CYCLES(FC)) dut_u (
    .ref_clk_i(ref_clk), .rst_i(rst), .cmd_stb_i(cmd_stb), .cmd_i(cmd),
    .wdata_i(wdata), .chan_sel_i(chan_sel), .pcm_data_i(pcm),
    .sig_in_i(sig_in), .sb_is_out_i(sb_out), .rdata_o(rdata),
    .rvalid_o(rvalid), .coef_en_o(coef_en), .lcl_loop_o(lcl_loop),
    .glb_loop_o(glb_loop), .synth_power_down_o(pd),
    .input_change_irq_o(irq));
  lmlf_host host_u (
    .ref_clk_i(ref_clk), .rvalid_i(rvalid), .rdata_i(rdata),
    .cmd_stb_o(cmd_stb), .cmd_o(cmd), .wdata_o(wdata),
    .chan_sel_o(chan_sel));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [6:0] code, input logic [7:0] dv,
                    input int ch);
    host_u.send(1'b1, code, dv, ch[1:0]);
    case (code)
      CODE_COEF:   m_coef[ch] = dv;
      CODE_LOCAL:  m_local[ch] = dv;
      CODE_COUNT:  m_cnt = dv;
      CODE_MODE:   m_mode = dv & 8'h0F;
      CODE_GLOBAL: m_glob = dv & 8'h3F;
      default: ;
    endcase
  endtask
  task automatic rchk(input string what, input logic [6:0] code,
                      input int ch, input logic [7:0] exp);
    logic [7:0] dv;
    host_u.rd(code, ch[1:0], dv);
    check(what, {24'h0, dv}, {24'h0, exp});
  endtask
  task automatic regs_chk;
    for (int ch = 0; ch < 4; ch++) begin
      rchk("coef", CODE_COEF, ch, m_coef[ch]);
      rchk("local", CODE_LOCAL, ch, m_local[ch]);
    end
    rchk("count", CODE_COUNT, 0, m_cnt);
    rchk("mode", CODE_MODE, 0, m_mode);
    rchk("global", CODE_GLOBAL, 0, m_glob);
    rchk("unmapped", 7'h10, 0, 8'h00);
    rchk("res_lo", CODE_RES_LO, 0, 8'h00);
    rchk("res_hi", CODE_RES_HI, 0, 8'h00);
  endtask
  task automatic applied_chk;
    for (int ch = 0; ch < 4; ch++) begin
      ec[8*ch +: 8] = m_coef[ch];
      el[3*ch +: 3] = m_local[ch][2:0];
    end
    check("coef_en", coef_en, ec);
    check("lcl_loop", {20'h0, lcl_loop}, {20'h0, el});
    check("glb_loop", {27'h0, glb_loop}, {27'h0, m_glob[4:0]});
    check("power_down", {31'h0, pd}, {31'h0, m_glob[5]});
  endtask

  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    final_report();
  end

  initial begin
    rst = 1'b1;
    pcm = 64'h0;
    sig_in = 20'h0;
    sb_out = 12'h0;
    n_fail = 0;
    comparisons = 0;
    for (int ch = 0; ch < 4; ch++) begin
      m_coef[ch] = RST_COEF;
      m_local[ch] = RST_ZERO;
    end
    m_cnt = 8'h00;
    m_mode = 8'h00;
    m_glob = 8'h00;
    void'($urandom(32'hE54B));
    repeat (4) @(posedge ref_clk);
    @(negedge ref_clk);
    rst = 1'b0;
    applied_chk();
    regs_chk();
    $display("reset values test done");
    for (int ch = 0; ch < 4; ch++) begin
      r = $urandom;
      // impedance match and scaling kept equal
      wr(CODE_COEF, {r[7:3], r[0], r[1:0]}, ch);
      if (ch == 0) check("coef_early", coef_en, {4{RST_COEF}});
      wr(CODE_LOCAL, r[15:8] & 8'h07, ch);
    end
    r = $urandom;
    wr(CODE_GLOBAL, r[7:0] & 8'hDF, 0);
    wr(CODE_COUNT, r[15:8], 0);
    rchk("count_rb", CODE_COUNT, 0, m_cnt);
    wr(CODE_MODE, r[23:16] & 8'hF7, 0);
    wr(CODE_RES_HI, 8'hFF, 0);
    regs_chk();
    cyc(2 * FC + 4);
    applied_chk();
    $display("write and apply test done");
    wr(CODE_GLOBAL, m_glob | 8'h20, 0);
    cyc(2);
    check("pd_on", {31'h0, pd}, 32'h1);
    wr(CODE_GLOBAL, 8'h00, 0);
    cyc(2 * FC + 4);
    applied_chk();
    $display("power down test done");
    for (int i = 0; i < 6; i++) begin
      c = i % 4;
      pcm = {$urandom, $urandom};
      wr(CODE_COUNT, (i == 5) ? 8'h03 : 8'h00, 0);
      wr(CODE_MODE, {4'h0, 1'b1, i >= 4, c[1:0]}, 0);
      cyc((m_cnt + 2) * FC + 8);
      wr(CODE_MODE, m_mode & 8'h07, 0);
      r[15:0] = pcm[16*c +: 16];
      if (i < 4) r[15:0] = {r[7:0], 8'h00};
      else if (i == 5 && r[15]) r[15:0] = -r[15:0];
      // low byte first so its ready bit is seen before the high byte read clears it
      rchk("res_lo", CODE_RES_LO, 0, {r[7:1], 1'b1});
      rchk("res_hi", CODE_RES_HI, 0, r[15:8]);
      rchk("res_lo_clr", CODE_RES_LO, 0, {r[7:1], 1'b0});
      cyc(2 * FC);
      rchk("res_hi_held", CODE_RES_HI, 0, r[15:8]);
    end
    $display("level meter test done");
    for (int ch = 0; ch < 4; ch++) begin
      sb_out = 12'h001 << (3 * ch);
      wr(CODE_LOCAL, 8'hF8, ch);
      for (int b = 0; b < 5; b++) begin
        sig_in[5*ch+b] = ~sig_in[5*ch+b];
        cyc(1);
        check("irq", {28'h0, irq}, (b == 2) ? 32'h0 : 32'h1 << ch);
      end
      wr(CODE_LOCAL, 8'h00, ch);
      sig_in[5*ch] = ~sig_in[5*ch];
      cyc(1);
      check("irq_masked", {28'h0, irq}, 32'h0);
    end
    $display("interrupt enable test done");
    final_report();
  end
endmodule
